// ===== common/b2s_regs.svh
// constants for the burst-of-two split-port sram core
// assumes inclusion by bare name from the package and the rtl files
`ifndef B2S_REGS_SVH
`define B2S_REGS_SVH

// data and address geometry
`define B2S_WORD_W 18
`define B2S_ADDR_W 18
`define B2S_BE_W 2
`define B2S_LANE_W 9
`define B2S_LANES 4
`define B2S_PAIR_W 36
`define B2S_DEPTH 262144

// byte-write lane positions inside one word
`define B2S_LANE0_MSB 8
`define B2S_LANE1_LSB 9
`define B2S_LANE1_MSB 17

// synchroniser and strap probe timing
`define B2S_SYNC_W 2
`define B2S_SYNC_RST 2'h3
`define B2S_CORE_CLK_PERIOD_NS 20
`define B2S_STRAP_WINDOW_NS 2000
`define B2S_STRAP_CYCLES \
  ((`B2S_STRAP_WINDOW_NS + `B2S_CORE_CLK_PERIOD_NS - 1) / `B2S_CORE_CLK_PERIOD_NS)
`define B2S_STRAP_CNT_W 8

`endif

// ===== common/b2s_pkg.sv
// shared types of the burst-of-two split-port sram core
// assumes the constants header is on the include path
`include "b2s_regs.svh"

package b2s_pkg;
  typedef logic [`B2S_WORD_W-1:0] b2s_word_t;
  typedef logic [`B2S_ADDR_W-1:0] b2s_addr_t;
  typedef logic [`B2S_BE_W-1:0] b2s_be_t;
  typedef logic [`B2S_PAIR_W-1:0] b2s_pair_t;
  typedef enum logic {STRAP_PROBE, STRAP_DONE} b2s_strap_e;
endpackage : b2s_pkg

// ===== common/b2s_burst_if.sv
// one two-word burst with its address and byte enables
// assumes the package is compiled first
`timescale 1ns/100ps

interface b2s_burst_if;
  logic valid;
  b2s_pkg::b2s_addr_t addr;
  b2s_pkg::b2s_word_t lo;
  b2s_pkg::b2s_word_t hi;
  b2s_pkg::b2s_be_t be_lo;
  b2s_pkg::b2s_be_t be_hi;

  modport src (output valid, addr, lo, hi, be_lo, be_hi);
  modport snk (input valid, addr, lo, hi, be_lo, be_hi);
endinterface : b2s_burst_if

// ===== rtl/b2s_wr_capture.sv
// write-port input registers on the input clock pair
// assumes k and k_n are complementary and i_rst is synchronous to k
`timescale 1ns/100ps
`include "b2s_regs.svh"

module b2s_wr_capture (
  // input clock pair and reset
  input wire logic i_k_clk,
  input wire logic i_k_n_clk,
  input wire logic i_rst,
  // write port pins
  input wire logic i_write_port_select_n,
  input wire logic [`B2S_BE_W-1:0] i_byte_write_select_n,
  input wire logic [`B2S_ADDR_W-1:0] i_addr,
  input wire logic [`B2S_WORD_W-1:0] i_wr_data,
  // captured burst
  b2s_burst_if.src o_wr
);
  logic start_reg;
  logic valid_reg;
  b2s_pkg::b2s_word_t lo_reg;
  b2s_pkg::b2s_word_t hi_reg;
  b2s_pkg::b2s_addr_t addr_reg;
  b2s_pkg::b2s_be_t be_lo_reg;
  b2s_pkg::b2s_be_t be_hi_reg;

  // first word only when the port is selected
  always_ff @(posedge i_k_clk) begin
    start_reg <= ~i_rst & ~i_write_port_select_n;
    if (~i_write_port_select_n) begin
      lo_reg <= i_wr_data;
      be_lo_reg <= ~i_byte_write_select_n;
    end
  end

  // address and second word ride the k_n rise
  always_ff @(posedge i_k_n_clk) begin
    valid_reg <= start_reg;
    if (start_reg) begin
      addr_reg <= i_addr;
      hi_reg <= i_wr_data;
      be_hi_reg <= ~i_byte_write_select_n;
    end
  end

  assign o_wr.valid = valid_reg;
  assign o_wr.addr = addr_reg;
  assign o_wr.lo = lo_reg;
  assign o_wr.hi = hi_reg;
  assign o_wr.be_lo = be_lo_reg;
  assign o_wr.be_hi = be_hi_reg;
endmodule : b2s_wr_capture

// ===== rtl/b2s_rd_drive.sv
// read-port ddr output registers on the output clock pair
// assumes the burst is stable across the rise of i_p_clk
`timescale 1ns/100ps
`include "b2s_regs.svh"

module b2s_rd_drive (
  // output clock pair and reset
  input wire logic i_p_clk,
  input wire logic i_n_clk,
  input wire logic i_rst,
  // burst to send
  b2s_burst_if.snk i_rd,
  // read data pins
  output logic [`B2S_WORD_W-1:0] o_rd_data,
  output logic o_rd_data_oe
);
  logic oe_reg;
  b2s_pkg::b2s_word_t lo_reg;
  b2s_pkg::b2s_word_t hold_reg;
  b2s_pkg::b2s_word_t hi_reg;

  // lower word and enable on the positive rise
  always_ff @(posedge i_p_clk) begin
    oe_reg <= ~i_rst & i_rd.valid;
    lo_reg <= i_rd.lo;
    hold_reg <= i_rd.hi;
  end

  // upper word on the negative rise
  always_ff @(posedge i_n_clk) begin
    hi_reg <= hold_reg;
  end

  // ddr select: lower half while p is high
  assign o_rd_data = i_p_clk ? lo_reg : hi_reg;
  assign o_rd_data_oe = oe_reg;
endmodule : b2s_rd_drive

// ===== rtl/b2s_core.sv
// top of the burst-of-two split-port sram core
// assumes k/k_n and c/c_n come from the controller; c and c_n
// are tied high for single-clock use; i_sys_rst stands in for power-up
//
// Notes on behaviour
// - accesses start on positive input clock rise
// - write data captured on both input clocks
// - port and byte selects registered on inputs
// - read data driven from output-clock registers
// - single-clock mode uses input clocks for output
// - two arrays of 256K by 18
// - every access moves two words, one address
// - read select low latches read address
// - lower read word follows next k rise
// - upper read word on negative output clock
// - outputs float after next c rise when idle
// - write select low, first word same edge
// - first write word into lower half, masked
// - k_n rise latches address and second word
// - combined 36 bits written at latched address
// - deselected write port ignores its inputs
// - one address bus shared by both ports
// - byte select 0 gates 8:0, 1 gates 17:9
// - powers up deselected, outputs floating
// - read of fresh write gets forwarded data
`timescale 1ns/100ps
`include "b2s_regs.svh"

module b2s_core (
  // core clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,

  // input clock pair
  input wire logic i_k_clk,
  input wire logic i_k_n_clk,

  // output clock pair, tied high for single-clock mode
  input wire logic i_c_clk,
  input wire logic i_c_n_clk,

  // shared address and port selects
  input wire logic [`B2S_ADDR_W-1:0] i_addr,
  input wire logic i_read_port_select_n,
  input wire logic i_write_port_select_n,
  input wire logic [`B2S_BE_W-1:0] i_byte_write_select_n,

  // write data
  input wire logic [`B2S_WORD_W-1:0] i_wr_data,

  // expansion straps, held low by the board
  input wire logic i_upper_addr_expand_tie_low_a,
  input wire logic i_upper_addr_expand_tie_low_b,

  // read data pins
  output logic [`B2S_WORD_W-1:0] o_rd_data,
  output logic o_rd_data_oe,

  // strap status
  output logic o_single_clk_mode
);

  // core domain: strap probe
  logic [`B2S_SYNC_W-1:0] c_sync_reg;
  logic [`B2S_SYNC_W-1:0] cn_sync_reg;
  logic seen_low_reg;
  logic seen_low_next;
  logic single_reg;
  logic [`B2S_STRAP_CNT_W-1:0] strap_cnt_reg;
  b2s_pkg::b2s_strap_e strap_reg;
  b2s_pkg::b2s_strap_e strap_next;
  logic probe_end;
  logic link_hold;

  // k domain
  logic [`B2S_SYNC_W-1:0] k_rst_sync_reg;
  logic k_rst;
  logic rd_start_reg;
  b2s_pkg::b2s_addr_t rd_addr_reg;
  b2s_pkg::b2s_pair_t mem_reg [0:`B2S_DEPTH-1];

  // output domain
  logic out_p_clk;
  logic out_n_clk;
  logic [`B2S_SYNC_W-1:0] o_rst_sync_reg;
  logic out_rst;

  // write commit and forwarding terms
  logic [`B2S_LANES-1:0] lane_en;
  b2s_pkg::b2s_pair_t lane_mask;
  b2s_pkg::b2s_pair_t wr_pair;
  b2s_pkg::b2s_pair_t array_pair;
  b2s_pkg::b2s_pair_t merged_pair;
  b2s_pkg::b2s_pair_t rd_pair;
  logic fwd_hit;

  // carriers between this module and its helpers
  b2s_burst_if wr_bus ();
  b2s_burst_if rd_bus ();

  // core domain
  // output clock levels are only looked at after two flops, since
  // they are free-running clocks unrelated to the core clock
  always_ff @(posedge i_core_clk) begin
    c_sync_reg <= {c_sync_reg[0], i_c_clk};
    cn_sync_reg <= {cn_sync_reg[0], i_c_n_clk};
  end

  // any low level on either output clock means a real c pair
  assign seen_low_next = seen_low_reg | ~c_sync_reg[1] | ~cn_sync_reg[1];
  assign probe_end = (strap_cnt_reg == `B2S_STRAP_CNT_W'(`B2S_STRAP_CYCLES - 1));

  // strap probe sequence
  always_comb begin
    strap_next = strap_reg;
    case (strap_reg)
      b2s_pkg::STRAP_PROBE: begin
        if (probe_end) begin
          strap_next = b2s_pkg::STRAP_DONE;
        end
      end
      b2s_pkg::STRAP_DONE: begin
        strap_next = b2s_pkg::STRAP_DONE;
      end
      default: begin
        strap_next = b2s_pkg::STRAP_PROBE;
      end
    endcase
  end

  // the strap is caught once after reset and then frozen
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      strap_reg <= b2s_pkg::STRAP_PROBE;
      strap_cnt_reg <= '0;
      seen_low_reg <= 1'b0;
      single_reg <= 1'b0;
    end else begin
      strap_reg <= strap_next;
      if (strap_reg == b2s_pkg::STRAP_PROBE) begin
        strap_cnt_reg <= strap_cnt_reg + `B2S_STRAP_CNT_W'(1);
        seen_low_reg <= seen_low_next;
        single_reg <= ~seen_low_next;
      end
    end
  end

  // the link stays deselected until the strap is known
  assign link_hold = i_sys_rst | (strap_reg != b2s_pkg::STRAP_DONE);
  assign o_single_clk_mode = single_reg;

  // output clock choice
  // the select is a strap frozen before the output side leaves
  // reset, so the mux never switches while data is moving
  assign out_p_clk = single_reg ? i_k_clk : i_c_clk;
  assign out_n_clk = single_reg ? i_k_n_clk : i_c_n_clk;

  // reset crossings into the link clocks
  always_ff @(posedge i_k_clk) begin
    k_rst_sync_reg <= {k_rst_sync_reg[0], link_hold};
  end
  assign k_rst = k_rst_sync_reg[1];

  always_ff @(posedge out_p_clk) begin
    o_rst_sync_reg <= {o_rst_sync_reg[0], link_hold};
  end
  assign out_rst = o_rst_sync_reg[1];

  // write port capture
  b2s_wr_capture u_wr_capture (
    .i_k_clk(i_k_clk),
    .i_k_n_clk(i_k_n_clk),
    .i_rst(k_rst),
    .i_write_port_select_n(i_write_port_select_n),
    .i_byte_write_select_n(i_byte_write_select_n),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .o_wr(wr_bus.src)
  );

  // byte lanes of the 36-bit pair: lower word lanes 0-1, upper 2-3
  assign lane_en = {wr_bus.be_hi, wr_bus.be_lo};
  assign wr_pair = {wr_bus.hi, wr_bus.lo};

  genvar lane;
  generate
    for (lane = 0; lane < `B2S_LANES; lane = lane + 1) begin : g_lane
      assign lane_mask[lane*`B2S_LANE_W +: `B2S_LANE_W] =
        {`B2S_LANE_W{lane_en[lane]}};
    end
  endgenerate

  // commit on the k rise after the k_n half arrives
  // a lane with its select high keeps the stored value
  always_ff @(posedge i_k_clk) begin
    if (wr_bus.valid) begin
      mem_reg[wr_bus.addr] <= (mem_reg[wr_bus.addr] & ~lane_mask)
        | (wr_pair & lane_mask);
    end
  end

  // read launch on the k rise
  // the address bus is sampled here for reads and at k_n for writes
  always_ff @(posedge i_k_clk) begin
    rd_start_reg <= ~k_rst & ~i_read_port_select_n;
    if (~i_read_port_select_n) begin
      rd_addr_reg <= i_addr;
    end
  end

  // array look-up with forwarding
  // a write begun at the same k rise is not in the array yet when
  // the read data is sampled, so its enabled lanes are merged in
  assign array_pair = mem_reg[rd_addr_reg];
  assign fwd_hit = wr_bus.valid & (wr_bus.addr == rd_addr_reg);
  assign merged_pair = (array_pair & ~lane_mask) | (wr_pair & lane_mask);
  assign rd_pair = fwd_hit ? merged_pair : array_pair;

  // burst handed to the output registers: lower word first
  assign rd_bus.valid = rd_start_reg;
  assign rd_bus.addr = rd_addr_reg;
  assign rd_bus.lo = rd_pair[`B2S_WORD_W-1:0];
  assign rd_bus.hi = rd_pair[`B2S_PAIR_W-1:`B2S_WORD_W];
  assign rd_bus.be_lo = '1;
  assign rd_bus.be_hi = '1;

  // read port output registers
  // limitation: c must rise with k or before the next k rise, since
  // the burst changes on each k rise
  b2s_rd_drive u_rd_drive (
    .i_p_clk(out_p_clk),
    .i_n_clk(out_n_clk),
    .i_rst(out_rst),
    .i_rd(rd_bus.snk),
    .o_rd_data(o_rd_data),
    .o_rd_data_oe(o_rd_data_oe)
  );

  // expansion straps carry no address in this density; the board
  // holds them low and the core ignores them
  logic unused_expand;
  assign unused_expand = i_upper_addr_expand_tie_low_a
    & i_upper_addr_expand_tie_low_b;

endmodule : b2s_core

// ===== tb/b2s_ctrl_model.sv
// controller model: free-running input clock pair and one-cycle port requests
// assumes the bench calls op only once the device has left reset
`timescale 1ns/100ps

module b2s_ctrl_model (
  // input clock pair
  output logic o_k_clk,
  output logic o_k_n_clk,
  // shared address, port selects and write data
  output logic [17:0] o_addr,
  output logic o_read_port_select_n,
  output logic o_write_port_select_n,
  output logic [1:0] o_byte_write_select_n,
  output logic [17:0] o_wr_data
);
  // K at 30 ns, offset so it never lines up with the core clock
  initial begin
    o_k_clk = 1'b0;
    o_read_port_select_n = 1'b1;
    o_write_port_select_n = 1'b1;
    o_addr = 18'h0;
    o_byte_write_select_n = 2'h3;
    o_wr_data = 18'h0;
    #7;
    forever #15 o_k_clk = ~o_k_clk;
  end
  assign o_k_n_clk = ~o_k_clk;

  // one K cycle: selects and word0 for K, then write address and word1 for K#
  task automatic op(input logic rd, input logic wr, input logic [17:0] ra, input logic [17:0] wa,
                    input logic [17:0] w0, input logic [17:0] w1,
                    input logic [1:0] b0, input logic [1:0] b1);
    @(posedge o_k_n_clk);
    #2;
    o_read_port_select_n = !rd;
    o_write_port_select_n = !wr;
    o_addr = ra;
    o_wr_data = wr ? w0 : ~o_wr_data; // idle data keeps moving
    o_byte_write_select_n = b0;
    @(posedge o_k_clk);
    #2;
    o_read_port_select_n = 1'b1;
    o_write_port_select_n = 1'b1;
    o_addr = wa;
    o_wr_data = wr ? w1 : ~o_wr_data;
    o_byte_write_select_n = b1;
  endtask : op
endmodule : b2s_ctrl_model

// ===== tb/b2s_core_chk.sv
// assertions on the core pins: read enable timing and strap status
// assumes C rises with K unless both output clocks are strapped high
`timescale 1ns/100ps

module b2s_core_chk (
  // clocks and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_k_clk,
  input wire logic i_k_n_clk,
  input wire logic i_c_clk,
  input wire logic i_c_n_clk,
  // read select and watched outputs
  input wire logic i_read_port_select_n,
  input wire logic o_rd_data_oe,
  input wire logic o_single_clk_mode
);
  logic [7:0] up_reg;
  logic arm_reg;
  logic rd_reg;
  wire logic arm_c = up_reg > 8'h8C;

  // cycles since reset; arm well after the strap probe ends
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) up_reg <= 8'h0;
    else if (up_reg != 8'hFF) up_reg <= up_reg + 8'h1;
  end

  // read taken at K, looked at from K# half a cycle later
  always_ff @(posedge i_k_clk) begin
    arm_reg <= arm_c && !i_sys_rst;
    rd_reg <= arm_reg && !i_read_port_select_n;
  end

  a_rd_oe_on:
    assert property (@(posedge i_k_n_clk) disable iff (i_sys_rst) rd_reg |=> o_rd_data_oe)
    else $error("read data not enabled after read");
  a_oe_float_idle:
    assert property (@(posedge i_k_n_clk) disable iff (i_sys_rst)
      arm_reg && !rd_reg |=> !o_rd_data_oe) else $error("read data driven with no read");
  a_oe_cause:
    assert property (@(posedge i_k_n_clk) disable iff (i_sys_rst)
      $rose(o_rd_data_oe) |-> $past(rd_reg)) else $error("enable rose without a read");
  a_b2b_hold:
    assert property (@(posedge i_k_n_clk) disable iff (i_sys_rst)
      rd_reg ##1 rd_reg |=> o_rd_data_oe && $stable(o_rd_data_oe)) else $error("gap in burst");
  a_rst_float:
    assert property (@(posedge i_core_clk) i_sys_rst [*8] |-> !o_rd_data_oe)
    else $error("read data driven in reset");
  a_mode_rst:
    assert property (@(posedge i_core_clk) i_sys_rst |=> !o_single_clk_mode)
    else $error("single clock mode set in reset");
  a_mode_strap:
    assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      $rose(o_single_clk_mode) |-> $past(i_c_clk) && $past(i_c_n_clk)) else $error("bad strap");
  a_mode_fixed:
    assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      arm_c |-> $stable(o_single_clk_mode)) else $error("strap changed in operation");

  c_read: cover property (@(posedge i_k_n_clk) rd_reg);
  c_b2b: cover property (@(posedge i_k_n_clk) rd_reg ##1 rd_reg);
  c_single: cover property (@(posedge i_core_clk) $rose(o_single_clk_mode));
endmodule : b2s_core_chk

bind b2s_core b2s_core_chk u_b2s_core_chk (.i_core_clk, .i_sys_rst, .i_k_clk, .i_k_n_clk,
  .i_c_clk, .i_c_n_clk, .i_read_port_select_n, .o_rd_data_oe, .o_single_clk_mode);

// ===== tb/test_burst2_split_port_sram_core.sv
// self-checking bench for the burst-of-two split-port sram core
// assumes the controller model and the checker are compiled first
`timescale 1ns/100ps

module test_burst2_split_port_sram_core;
  typedef struct {
    logic rd, wr;
    logic [17:0] ra, wa, w0, w1;
    logic [1:0] b0, b1;
  } b2s_row_s;
  logic i_core_clk, i_sys_rst, single_mode, live, rd_q, exp_oe;
  wire logic i_k_clk, i_k_n_clk, i_read_port_select_n, i_write_port_select_n;
  wire logic [17:0] i_addr, i_wr_data;
  wire logic [1:0] i_byte_write_select_n;
  wire logic i_c_clk = single_mode | i_k_clk;
  wire logic i_c_n_clk = single_mode | i_k_n_clk;
  logic [17:0] o_rd_data;
  logic o_rd_data_oe, o_single_clk_mode;
  logic [35:0] mem [int];
  logic [35:0] exp_q [$];
  logic [35:0] e;
  int miscompares, total_checks;
  // rd, wr, read addr, write addr, word0, word1, byte selects of each word
  b2s_row_s rows [9] = '{
    '{1'b0, 1'b1, 18'h0, 18'h10, 18'h12345, 18'h2ABCD, 2'h0, 2'h0},
    '{1'b0, 1'b1, 18'h0, 18'h3FFFF, 18'h3FFFF, 18'h00001, 2'h0, 2'h0},
    '{1'b1, 1'b1, 18'h10, 18'h20, 18'h0F0F0, 18'h30303, 2'h0, 2'h0},
    '{1'b1, 1'b0, 18'h3FFFF, 18'h0, 18'h0, 18'h0, 2'h3, 2'h3},
    '{1'b0, 1'b1, 18'h0, 18'h10, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h1},
    '{1'b1, 1'b1, 18'h10, 18'h20, 18'h15555, 18'h2AAAA, 2'h3, 2'h3},
    '{1'b1, 1'b1, 18'h20, 18'h20, 18'h11111, 18'h22222, 2'h1, 2'h2},
    '{1'b0, 1'b0, 18'h20, 18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0},
    '{1'b1, 1'b0, 18'h20, 18'h0, 18'h0, 18'h0, 2'h3, 2'h3}};

  // device under test; expansion straps stay low as the board must hold them
  b2s_core u_b2s_core (
    .i_core_clk, .i_sys_rst, .i_k_clk, .i_k_n_clk, .i_c_clk, .i_c_n_clk, .i_addr,
    .i_read_port_select_n, .i_write_port_select_n, .i_byte_write_select_n, .i_wr_data,
    .i_upper_addr_expand_tie_low_a(1'b0),
    .i_upper_addr_expand_tie_low_b(1'b0),
    .o_rd_data, .o_rd_data_oe, .o_single_clk_mode);

  b2s_ctrl_model u_b2s_ctrl_model (
    .o_k_clk(i_k_clk), .o_k_n_clk(i_k_n_clk), .o_addr(i_addr),
    .o_read_port_select_n(i_read_port_select_n),
    .o_write_port_select_n(i_write_port_select_n),
    .o_byte_write_select_n(i_byte_write_select_n), .o_wr_data(i_wr_data));

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  task automatic chk_data(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_flag(input logic got, input logic exp);
    chk_data({17'h0, got}, {17'h0, exp});
  endtask : chk_flag

  // shadow array updated lane by lane before the request, so same-cycle reads see it
  task automatic run(input b2s_row_s r);
    logic [35:0] v;
    v = mem.exists(r.wa) ? mem[r.wa] : 36'h0;
    if (r.wr) begin
      if (!r.b0[0]) v[8:0] = r.w0[8:0];
      if (!r.b0[1]) v[17:9] = r.w0[17:9];
      if (!r.b1[0]) v[26:18] = r.w1[8:0];
      if (!r.b1[1]) v[35:27] = r.w1[17:9];
      mem[r.wa] = v;
    end
    if (r.rd) exp_q.push_back(mem[r.ra]);
    u_b2s_ctrl_model.op(r.rd, r.wr, r.ra, r.wa, r.w0, r.w1, r.b0, r.b1);
  endtask : run

  // reset long enough for every clock, then sit out the strap probe
  task automatic do_reset(input logic single);
    repeat (4) @(posedge i_k_clk);
    live = 1'b0;
    @(posedge i_core_clk);
    #2;
    i_sys_rst = 1'b1;
    single_mode = single;
    repeat (10) @(posedge i_core_clk);
    #2;
    chk_flag(o_rd_data_oe, 1'b0);
    chk_flag(o_single_clk_mode, 1'b0);
    i_sys_rst = 1'b0;
    repeat (150) @(posedge i_core_clk);
    #2;
    chk_flag(o_single_clk_mode, single);
    live = 1'b1;
  endtask : do_reset

  // read monitor: enable and lower word just after K, upper word just after K#
  always @(posedge i_k_clk) begin
    exp_oe = rd_q;
    rd_q = live && (i_read_port_select_n === 1'b0);
    #5;
    if (live) begin
      chk_flag(o_rd_data_oe, exp_oe);
      if (exp_oe) begin
        e = exp_q.pop_front();
        chk_data(o_rd_data, e[17:0]);
        @(posedge i_k_n_clk);
        #5;
        chk_data(o_rd_data, e[35:18]);
      end
    end
  end

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    i_sys_rst = 1'b1;
    single_mode = 1'b0;
    live = 1'b0;
    rd_q = 1'b0;
    miscompares = 0;
    total_checks = 0;
    do_reset(1'b0);
    $display("test reset done");
    foreach (rows[i]) run(rows[i]);
    $display("test rows done");
    do_reset(1'b1);
    run('{1'b1, 1'b1, 18'h5, 18'h5, 18'h3A5A5, 18'h05A5A, 2'h0, 2'h0});
    run('{1'b1, 1'b0, 18'h5, 18'h0, 18'h0, 18'h0, 2'h3, 2'h3});
    repeat (4) @(posedge i_k_clk);
    $display("test single clock done");
    end_of_test();
  end

  // watchdog at several times the expected run length
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
endmodule : test_burst2_split_port_sram_core
